/* File: pkg/oamx_pkg.sv */
// package for the or/and-move instruction execute block
// assumes a 14-bit instruction word and 8-bit data path
package oamx_pkg;
    // ****************************************************************
    // widths and field positions
    // ****************************************************************
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DIR_BIT = 7;
    // ****************************************************************
    // opcode patterns
    // ****************************************************************
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    localparam logic [5:0] OP_OR_REG = 6'h04;
    localparam logic [5:0] OP_MOVE_REG = 6'h08;
    localparam logic [3:0] OP_LOAD_LIT = 4'hc;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;

    typedef enum logic [2:0] {
        OAMX_NONE,
        OAMX_OR_LIT,
        OAMX_OR_REG,
        OAMX_MOVE_REG,
        OAMX_LOAD_LIT
    } oamx_op_t;

    // register file write request
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } oamx_fwr_t;
endpackage

/* File: hw/oamx_exec.sv */
// execute logic for four single-word instructions
// holds the working accumulator and the zero flag; the other status
// bits and the program counter stay with the rest of the core
// assumes the fetch stage presents one instruction per cycle with a valid
// strobe and the register file answers reads combinationally
`timescale 1ns/10ps
`default_nettype none
module oamx_exec (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    output logic [6:0] o_file_raddr,
    input wire logic [7:0] i_file_rdata,
    output oamx_pkg::oamx_fwr_t o_file_wr,
    output logic [7:0] o_acc,
    output logic o_zero,
    output logic o_handled
);
    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic oamx_pkg::oamx_op_t oamx_decode(input logic [13:0] ins);
        if (ins[13:8] == oamx_pkg::OP_OR_LIT) begin
            return oamx_pkg::OAMX_OR_LIT;
        end else if (ins[13:8] == oamx_pkg::OP_OR_REG) begin
            return oamx_pkg::OAMX_OR_REG;
        end else if (ins[13:8] == oamx_pkg::OP_MOVE_REG) begin
            return oamx_pkg::OAMX_MOVE_REG;
        end else if (ins[13:10] == oamx_pkg::OP_LOAD_LIT) begin // bits 9:8 ignored
            return oamx_pkg::OAMX_LOAD_LIT;
        end else begin
            return oamx_pkg::OAMX_NONE;
        end
    endfunction

    // ****************************************************************
    // instruction fields and destination decode
    // ****************************************************************
    function automatic logic [6:0] oamx_file_addr(input logic [13:0] ins);
        return ins[6:0];
    endfunction

    function automatic logic [7:0] oamx_literal(input logic [13:0] ins);
        return ins[7:0];
    endfunction

    // register forms only; d=1 turns the accumulator update into a file write
    function automatic logic oamx_writes_file(input oamx_pkg::oamx_op_t kind, input logic dir);
        logic w;
        w = 1'b0;
        unique case (kind)
            oamx_pkg::OAMX_OR_REG: begin
                w = dir;
            end
            oamx_pkg::OAMX_MOVE_REG: begin
                w = dir;
            end
            oamx_pkg::OAMX_OR_LIT, oamx_pkg::OAMX_LOAD_LIT, oamx_pkg::OAMX_NONE: begin
                w = 1'b0;
            end
        endcase
        return w;
    endfunction

    function automatic logic oamx_writes_acc(input oamx_pkg::oamx_op_t kind, input logic dir);
        logic w;
        w = 1'b0;
        unique case (kind)
            oamx_pkg::OAMX_OR_LIT, oamx_pkg::OAMX_LOAD_LIT: begin
                w = 1'b1;
            end
            oamx_pkg::OAMX_OR_REG, oamx_pkg::OAMX_MOVE_REG: begin
                w = ~dir;
            end
            oamx_pkg::OAMX_NONE: begin
                w = 1'b0;
            end
        endcase
        return w;
    endfunction

    // the literal load is the one form here that leaves the flags alone
    function automatic logic oamx_sets_zero(input oamx_pkg::oamx_op_t kind);
        logic s;
        s = 1'b0;
        unique case (kind)
            oamx_pkg::OAMX_OR_LIT, oamx_pkg::OAMX_OR_REG: begin
                s = 1'b1;
            end
            oamx_pkg::OAMX_MOVE_REG: begin
                s = 1'b1; // zero test even with d=1
            end
            oamx_pkg::OAMX_LOAD_LIT, oamx_pkg::OAMX_NONE: begin
                s = 1'b0; // flags untouched
            end
        endcase
        return s;
    endfunction

    function automatic logic oamx_is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    oamx_pkg::oamx_op_t op;
    logic [7:0] lit;
    logic to_file;
    logic [7:0] result;
    logic upd_zero;
    logic upd_acc;

    assign op = i_instr_valid ? oamx_decode(i_instr) : oamx_pkg::OAMX_NONE;
    assign lit = oamx_literal(i_instr);
    assign to_file = i_instr[oamx_pkg::DIR_BIT];
    assign o_file_raddr = oamx_file_addr(i_instr);
    assign upd_acc = oamx_writes_acc(op, to_file);
    assign upd_zero = oamx_sets_zero(op);

    // ****************************************************************
    // file operand
    // ****************************************************************
    // the write port is registered, so a write issued in the last cycle
    // has not reached the register file yet; forwarding it keeps
    // back-to-back instructions on one register single-cycle
    logic fwd_hit;
    logic [7:0] file_val;

    assign fwd_hit = o_file_wr.we && (o_file_wr.addr == oamx_file_addr(i_instr));
    assign file_val = fwd_hit ? o_file_wr.data : i_file_rdata;

    // ****************************************************************
    // datapath
    // ****************************************************************
    always_comb begin
        result = 8'h00;
        unique case (op)
            oamx_pkg::OAMX_OR_LIT: begin
                result = o_acc | lit;
            end
            oamx_pkg::OAMX_OR_REG: begin
                result = o_acc | file_val;
            end
            oamx_pkg::OAMX_MOVE_REG: begin
                result = file_val;
            end
            oamx_pkg::OAMX_LOAD_LIT: begin
                result = lit;
            end
            oamx_pkg::OAMX_NONE: begin
                result = 8'h00;
            end
        endcase
    end

    oamx_pkg::oamx_fwr_t next_file_wr;
    logic next_handled;

    always_comb begin
        next_file_wr.we = oamx_writes_file(op, to_file);
        next_file_wr.addr = oamx_file_addr(i_instr);
        next_file_wr.data = result;
        next_handled = (op != oamx_pkg::OAMX_NONE);
    end

    // ****************************************************************
    // working accumulator
    // ****************************************************************
    // idle cycles and foreign opcodes leave it as it was
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_acc <= oamx_pkg::ACC_RST;
        end else if (upd_acc) begin
            o_acc <= result;
        end
    end

    // ****************************************************************
    // zero flag
    // ****************************************************************
    // a literal load may sit between a zero test and the code that reads
    // the flag without disturbing it
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_zero <= oamx_pkg::ZERO_RST;
        end else if (upd_zero) begin
            o_zero <= oamx_is_zero(result);
        end
    end

    // ****************************************************************
    // file write request
    // ****************************************************************
    // registered so data outputs come from flip-flops; the price is the
    // forwarding path on the file operand
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_file_wr <= '0;
        end else begin
            o_file_wr <= next_file_wr;
        end
    end

    // ****************************************************************
    // retire pulse
    // ****************************************************************
    // a foreign opcode or an idle cycle gives no pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_handled <= 1'b0;
        end else begin
            o_handled <= next_handled;
        end
    end
endmodule // oamx_exec
`default_nettype wire

/* File: test/oamx_exec_props.sv */
// port checker for oamx_exec
// bound to every oamx_exec instance
`timescale 1ns/10ps
`default_nettype none
module oamx_exec_props (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    input wire logic [6:0] o_file_raddr,
    input wire logic [7:0] i_file_rdata,
    input wire oamx_pkg::oamx_fwr_t o_file_wr,
    input wire logic [7:0] o_acc,
    input wire logic o_zero,
    input wire logic o_handled
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    wire logic [6:0] op = i_instr_valid ? i_instr[13:7] : 7'h7f;
    // a write issued last cycle reaches the file one edge late, so the
    // register's present value is the pending write when addresses match
    wire logic [7:0] file_now = (o_file_wr.we && o_file_wr.addr == i_instr[6:0]) ? o_file_wr.data : i_file_rdata;
    or_lit_a: assert property (op[6:1] == 6'h38 |=> o_acc == ($past(o_acc) | $past(i_instr[7:0]))
        && o_zero == (o_acc == 8'h0) && o_handled) else $error("or literal bad");
    or_to_acc_a: assert property (op == 7'h08 |=> o_acc == ($past(o_acc) | $past(file_now))
        && !o_file_wr.we) else $error("or to acc bad");
    or_to_file_a: assert property (op == 7'h09 |=> o_file_wr.we && $stable(o_acc)
        && o_file_wr.data == ($past(o_acc) | $past(file_now))) else $error("or to file bad");
    move_acc_a: assert property (op == 7'h10 |=> o_acc == $past(file_now)
        && o_zero == (o_acc == 8'h0)) else $error("move to acc bad");
    move_zero_a: assert property (op == 7'h11 |=> o_file_wr.we && o_file_wr.addr == $past(i_instr[6:0])
        && o_zero == ($past(file_now) == 8'h0)) else $error("move test bad");
    load_lit_a: assert property (op[6:3] == 4'hc |=> o_acc == $past(i_instr[7:0])
        && $stable(o_zero) && o_handled) else $error("load literal bad");
    refuse_idle_a: assert property (!i_instr_valid |=> !o_handled && !o_file_wr.we
        && $stable(o_acc)) else $error("idle cycle changed state");
    other_op_a: assert property (i_instr_valid && op[6:1] != 6'h38 && op[6:1] != 6'h04 && op[6:1] != 6'h08
        && op[6:3] != 4'hc |=> !o_handled && !o_file_wr.we && $stable(o_acc) && $stable(o_zero))
        else $error("foreign opcode changed state");
    read_addr_a: assert property (o_file_raddr == i_instr[6:0]) else $error("read address bad");
endmodule // oamx_exec_props
bind oamx_exec oamx_exec_props u_props (.*);
`default_nettype wire

/* File: test/oamx_rf_model.sv */
// register file stand-in with same-cycle read
// assumes writes arrive on the design's write port
`timescale 1ns/10ps
`default_nettype none
module oamx_rf_model (
    input wire logic i_clk,
    input wire logic [6:0] i_raddr,
    input wire oamx_pkg::oamx_fwr_t i_wr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [128];
    initial foreach (mem[n]) mem[n] = 8'(n * 37);
    assign o_rdata = mem[i_raddr];
    always @(posedge i_clk) if (i_wr.we) mem[i_wr.addr] <= i_wr.data;
endmodule // oamx_rf_model
`default_nettype wire

/* File: test/oamx_exec_bench.sv */
// self-checking bench for oamx_exec
// assumes oamx_rf_model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module oamx_exec_bench;
    logic clk = 0, nrst = 0, v = 0, h, z, ez = 0;
    logic [13:0] ins = 0, rw;
    logic [6:0] ra;
    logic [7:0] rd, acc, ea = 0, m [128];
    logic [25:0] e;
    oamx_pkg::oamx_fwr_t wr;
    int bad_count = 0, comparisons = 0, k, rk;
    // idle address and data are masked: only a live write carries meaning
    wire logic [25:0] obs = {wr.we, wr.we ? wr.addr : 7'h0, wr.we ? wr.data : 8'h0, acc, z, h};
    always #5 clk = ~clk;
    oamx_exec u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_instr_valid(v), .i_instr(ins), .o_file_raddr(ra),
        .i_file_rdata(rd), .o_file_wr(wr), .o_acc(acc), .o_zero(z), .o_handled(h));
    oamx_rf_model u_rf (.i_clk(clk), .i_raddr(ra), .i_wr(wr), .o_rdata(rd));
    function automatic logic [25:0] predict();
        logic [7:0] r;
        logic w;
        r = k == 0 ? ea | ins[7:0] : k == 1 ? ea | m[ins[6:0]] : k == 2 ? m[ins[6:0]] : ins[7:0];
        w = k inside {1, 2} && ins[7];
        if (k < 4 && w) m[ins[6:0]] = r;
        else if (k < 4) ea = r;
        if (k < 3) ez = r == 8'h0;
        return {w, w ? ins[6:0] : 7'h0, w ? r : 8'h0, ea, ez, k < 4};
    endfunction
    task automatic chk(input string what, input logic [25:0] s, input logic [25:0] x);
        comparisons++;
        if (s !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, x, s);
        end
    endtask
    // drives one word for one cycle from a falling edge, then checks at the next one
    task automatic issue(input int kind, input logic [13:0] word);
        k = kind;
        v = kind != 5;
        ins = word;
        e = predict();
        @(negedge clk);
        chk("outputs", obs, e);
        chk("read address", 26'(ra), 26'(ins[6:0]));
    endtask
    task automatic close_out;
        $display("compared %0d, mismatched %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #50000;
        bad_count++;
        close_out;
    end
    initial begin
        void'($urandom(32'hf0de));
        foreach (m[n]) m[n] = 8'(n * 37);
        repeat (3) @(negedge clk);
        nrst = 1;
        chk("outputs after reset", obs, 26'h0);
        issue(3, 14'h309a);
        issue(0, 14'h3835);
        issue(3, 14'h335a);
        issue(2, 14'h0880);
        issue(3, 14'h3300);
        issue(1, 14'h0480);
        issue(1, 14'h0480);
        issue(2, 14'h0805);
        issue(5, 14'h3835);
        issue(4, 14'h0a85);
        $display("test corner_cases done");
        repeat (2000) begin
            rk = $urandom % 6;
            rw = 14'($urandom);
            if ($urandom % 4 == 0) rw[7:0] = 8'h0;
            if (rk == 3) rw[13:10] = 4'hc;
            else if (rk < 5) rw[13:8] = rk == 0 ? 6'h38 : rk == 1 ? 6'h04 : rk == 2 ? 6'h08 : 6'h0a;
            issue(rk, rw);
        end
        $display("test random_mix done");
        nrst = 0;
        v = 0;
        @(negedge clk);
        nrst = 1;
        ea = 8'h00;
        ez = 1'b0;
        chk("outputs after mid reset", obs, 26'h0);
        issue(0, 14'h3800);
        $display("test mid_reset done");
        close_out;
    end
endmodule // oamx_exec_bench
`default_nettype wire
